// ### include/acr_cfg.svh
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
// bank geometry
`define ACR_REG_COUNT 8
`define ACR_RST_VALUE 8'h00
// register offsets
`define ACR_OFS_STATUS 4'h0
`define ACR_OFS_PWRDN 4'h1
`define ACR_OFS_PROTO 4'h2
`define ACR_OFS_LANES 4'h3
`define ACR_OFS_RETIMER 4'h4
`define ACR_OFS_WORDFMT 4'h5
`define ACR_OFS_AVERAGE 4'h6
`define ACR_OFS_HALFREF 4'h7
// writable bit masks
`define ACR_STATUS_MASK 8'h06
`define ACR_PWRDN_MASK 8'h2B
`define ACR_CFG_MASK 8'hFF
// field positions
`define ACR_BIT_ZONE2 2
`define ACR_BIT_ABORT 1
`define ACR_BIT_HALFREF 5
`define ACR_BIT_CHB 3
`define ACR_BIT_CHA 1
`define ACR_BIT_IREF 0
`define ACR_BIT_CPOL 1
`define ACR_BIT_CPHA 0
// command operation codes
`define ACR_OP_WRITE 4'h1
`define ACR_OP_READ 4'h2
`define ACR_OP_SET 4'h5
`define ACR_OP_CLEAR 4'h6
// frame length in capture edges of the serial clock
`define ACR_FRAME_BITS 5'h10
`define ACR_FRAME_MAX 5'h11
`endif

// ### include/acr_pkg.sv
`include "acr_cfg.svh"
package acr_pkg;
  typedef enum {rx_idle, rx_active} acr_rx_state_type;
  typedef logic [7:0] acr_byte_type;
  typedef logic [`ACR_REG_COUNT-1:0][7:0] acr_bank_type;
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] addr;
    logic [7:0] data;
  } acr_cmd_type;
endpackage

// ### include/acr_link_if.sv
`timescale 1ns/1ps
interface acr_link_if;
  logic frame_valid;
  logic [15:0] frame_word;
  logic cs_fall;
  logic [15:0] tx_word;
  logic capture_rise;
  modport rx (output frame_valid, frame_word, cs_fall, input tx_word, capture_rise);
  modport core (input frame_valid, frame_word, cs_fall, output tx_word, capture_rise);
endinterface

// ### core/acr_serial_rx.sv
`timescale 1ns/1ps
module acr_serial_rx
  import acr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // serial pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  input wire logic conversion_start_pin,
  output logic sdo_out,
  output logic sdo_oe,
  // link to register core
  acr_link_if.rx lnk
);
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic cs_p;
  logic sclk_p;
  acr_rx_state_type st, next_st;
  logic [4:0] cnt, next_cnt;
  logic [15:0] shreg, next_shreg;
  logic [15:0] txsh, next_txsh;
  logic conv_ok, next_conv_ok;
  logic next_sdo_out, next_sdo_oe;
  logic fv, next_fv;
  logic [15:0] fw, next_fw;
  logic csf, next_csf;
  logic cs_b, sclk_b, sdi_b, conv_b;
  logic cap, launch;

  // second stage and edge detection
  assign cs_b = sync_b[0];
  assign sclk_b = sync_b[1];
  assign sdi_b = sync_b[2];
  assign conv_b = sync_b[3];
  assign cap = lnk.capture_rise ? (sclk_b & ~sclk_p) : (~sclk_b & sclk_p);
  assign launch = lnk.capture_rise ? (~sclk_b & sclk_p) : (sclk_b & ~sclk_p);
  assign lnk.frame_valid = fv;
  assign lnk.frame_word = fw;
  assign lnk.cs_fall = csf;

  // frame shifter
  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_shreg = shreg;
    next_txsh = txsh;
    next_conv_ok = conv_ok & conv_b;
    next_sdo_out = sdo_out;
    next_sdo_oe = sdo_oe;
    next_fv = 1'b0;
    next_fw = fw;
    next_csf = 1'b0;
    case (st)
      rx_idle:
        if (cs_p & ~cs_b)
        begin
          next_st = rx_active;
          next_cnt = 5'h00;
          next_txsh = lnk.tx_word;
          next_sdo_out = lnk.tx_word[15];
          next_sdo_oe = 1'b1;
          next_conv_ok = conv_b;
          next_csf = 1'b1;
        end
      rx_active:
        if (cs_b)
        begin
          next_st = rx_idle;
          next_sdo_oe = 1'b0;
          next_sdo_out = 1'b0;
          if (cnt == `ACR_FRAME_BITS && conv_ok)
          begin
            next_fv = 1'b1;
            next_fw = shreg;
          end
        end
        else
        begin
          if (cap)
          begin
            next_shreg = {shreg[14:0], sdi_b};
            if (cnt != `ACR_FRAME_MAX)
              next_cnt = cnt + 5'h01;
          end
          if (launch && cnt != 5'h00)
          begin
            next_txsh = {txsh[14:0], 1'b0};
            next_sdo_out = txsh[14];
          end
        end
      default:
        next_st = rx_idle;
    endcase
  end

  // registers, pins pass two flops first
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_a <= 4'h1;
      sync_b <= 4'h1;
      cs_p <= 1'b1;
      sclk_p <= 1'b0;
      st <= rx_idle;
      cnt <= 5'h00;
      shreg <= 16'h0000;
      txsh <= 16'h0000;
      conv_ok <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
      fv <= 1'b0;
      fw <= 16'h0000;
      csf <= 1'b0;
    end
    else if (clk_en)
    begin
      sync_a <= {conversion_start_pin, sdi_pin, sclk_pin, cs_n_pin};
      sync_b <= sync_a;
      cs_p <= cs_b;
      sclk_p <= sclk_b;
      st <= next_st;
      cnt <= next_cnt;
      shreg <= next_shreg;
      txsh <= next_txsh;
      conv_ok <= next_conv_ok;
      sdo_out <= next_sdo_out;
      sdo_oe <= next_sdo_oe;
      fv <= next_fv;
      fw <= next_fw;
      csf <= next_csf;
    end
  end
endmodule // acr_serial_rx

// ### core/acr_regs.sv
`timescale 1ns/1ps
// Function
// - eight byte registers at offsets 0 to 7, all reset to zero
// - status bits 7 to 3 are read-only and read as zero
// - status bit 0 is read-only and reads as zero
// - status bit 2 sets on late-window transfer, cleared by writing one
// - status bit 1 sets on chip-select fall during averaging, write one clears
// - power-down bits 5,3,1,0 writable; other bits read zero
// - 16-bit frame command_operation_field, address, data; start pin high; 1 writes, 2 reads
// - read data returns in the frame after the read command
// - power-down bits switch off half-reference, channel B, channel A, reference
module acr_regs
  import acr_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // serial command pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  input wire logic conversion_start_pin,
  output logic sdo_out,
  output logic sdo_oe,
  // datapath events, same clock
  input wire logic late_window_evt,
  input wire logic averaging_busy,
  // status flags
  output logic late_window_transfer_flag,
  output logic averaging_abort_flag,
  // power-down controls
  output logic half_reference_buffer_off,
  output logic channel_b_converter_off,
  output logic channel_a_converter_off,
  output logic internal_reference_off,
  // configuration bytes
  output logic [7:0] read_protocol_select,
  output logic [7:0] output_lane_count,
  output logic [7:0] clock_retimer_setup,
  output logic [7:0] output_word_format,
  output logic [7:0] averaging_setup,
  output logic [7:0] half_reference_offset
);
  acr_link_if lnk ();
  acr_bank_type regs_q, next_regs;
  acr_byte_type rd_hold, next_rd_hold;
  acr_cmd_type cmd;
  acr_byte_type status_clr;
  acr_byte_type status_set;
  logic abort_evt;

  // writable mask of each offset
  function automatic acr_byte_type wmask(input logic [3:0] a);
    case (a)
      `ACR_OFS_STATUS: wmask = `ACR_STATUS_MASK;
      `ACR_OFS_PWRDN: wmask = `ACR_PWRDN_MASK;
      default: wmask = `ACR_CFG_MASK;
    endcase
  endfunction

  // new byte for write, set and clear commands
  function automatic acr_byte_type apply_op(input logic [3:0] op,
                                            input acr_byte_type q,
                                            input acr_byte_type d,
                                            input acr_byte_type m);
    case (op)
      `ACR_OP_WRITE: apply_op = (q & ~m) | (d & m);
      `ACR_OP_SET: apply_op = q | (d & m);
      `ACR_OP_CLEAR: apply_op = q & ~(d & m);
      default: apply_op = q;
    endcase
  endfunction

  // serial frame receiver
  acr_serial_rx u_rx (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .sdi_pin(sdi_pin),
    .conversion_start_pin(conversion_start_pin),
    .sdo_out(sdo_out),
    .sdo_oe(sdo_oe),
    .lnk(lnk.rx)
  );

  // capture edge from polarity and phase, answer word
  assign lnk.capture_rise =
    regs_q[`ACR_OFS_PROTO][`ACR_BIT_CPOL] == regs_q[`ACR_OFS_PROTO][`ACR_BIT_CPHA];
  assign lnk.tx_word = {rd_hold, 8'h00};
  assign cmd = lnk.frame_word;

  // status events and host clears
  assign abort_evt = lnk.cs_fall & averaging_busy;
  always_comb
  begin
    status_set = 8'h00;
    status_set[`ACR_BIT_ZONE2] = late_window_evt;
    status_set[`ACR_BIT_ABORT] = abort_evt;
    status_clr = 8'h00;
    if (lnk.frame_valid && cmd.addr == `ACR_OFS_STATUS &&
        (cmd.op == `ACR_OP_WRITE || cmd.op == `ACR_OP_CLEAR))
      status_clr = cmd.data & `ACR_STATUS_MASK;
  end

  // bank next values
  always_comb
  begin
    next_regs = regs_q;
    next_rd_hold = rd_hold;
    if (lnk.cs_fall)
      next_rd_hold = 8'h00;
    if (lnk.frame_valid && !cmd.addr[3])
    begin
      if (cmd.op == `ACR_OP_READ)
        next_rd_hold = regs_q[cmd.addr[2:0]];
      else if (cmd.addr != `ACR_OFS_STATUS)
        next_regs[cmd.addr[2:0]] = apply_op(cmd.op, regs_q[cmd.addr[2:0]],
                                            cmd.data, wmask(cmd.addr));
    end
    // set wins over clear, reserved bits forced low
    next_regs[`ACR_OFS_STATUS] =
      ((regs_q[`ACR_OFS_STATUS] & ~status_clr) | status_set) & `ACR_STATUS_MASK;
  end

  // bank registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      regs_q <= '0;
      rd_hold <= `ACR_RST_VALUE;
    end
    else if (clk_en)
    begin
      regs_q <= next_regs;
      rd_hold <= next_rd_hold;
    end
  end

  // outputs straight from the bank
  assign late_window_transfer_flag = regs_q[`ACR_OFS_STATUS][`ACR_BIT_ZONE2];
  assign averaging_abort_flag = regs_q[`ACR_OFS_STATUS][`ACR_BIT_ABORT];
  assign half_reference_buffer_off = regs_q[`ACR_OFS_PWRDN][`ACR_BIT_HALFREF];
  assign channel_b_converter_off = regs_q[`ACR_OFS_PWRDN][`ACR_BIT_CHB];
  assign channel_a_converter_off = regs_q[`ACR_OFS_PWRDN][`ACR_BIT_CHA];
  assign internal_reference_off = regs_q[`ACR_OFS_PWRDN][`ACR_BIT_IREF];
  assign read_protocol_select = regs_q[`ACR_OFS_PROTO];
  assign output_lane_count = regs_q[`ACR_OFS_LANES];
  assign clock_retimer_setup = regs_q[`ACR_OFS_RETIMER];
  assign output_word_format = regs_q[`ACR_OFS_WORDFMT];
  assign averaging_setup = regs_q[`ACR_OFS_AVERAGE];
  assign half_reference_offset = regs_q[`ACR_OFS_HALFREF];

  // bank clears on reset
  chk_reset_zero: assert property (@(posedge ref_clk)
    sys_rst |=> regs_q == '0 && rd_hold == 8'h00)
    else $error("bank not zero after reset");

  // status reserved bits read zero
  chk_status_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lnk.frame_valid && clk_en && cmd.op == `ACR_OP_READ && cmd.addr == `ACR_OFS_STATUS
    |=> rd_hold[7:3] == 5'h00)
    else $error("status high bits not zero");

  chk_status_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 !regs_q[`ACR_OFS_STATUS][0])
    else $error("status bit 0 not zero");

  // late-window flag sets and sticks
  chk_zone2_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    late_window_evt && clk_en |=> late_window_transfer_flag)
    else $error("late-window flag missed");

  chk_zone2_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    late_window_transfer_flag && !status_clr[`ACR_BIT_ZONE2]
    |=> late_window_transfer_flag)
    else $error("late-window flag dropped");

  // abort flag sets on chip-select fall while averaging
  chk_abort_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lnk.cs_fall && averaging_busy && clk_en |=> averaging_abort_flag)
    else $error("abort flag missed");

  chk_abort_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && status_clr[`ACR_BIT_ABORT] && !abort_evt |=> !averaging_abort_flag)
    else $error("abort flag not cleared");

  // power-down reserved bits stay low
  chk_pd_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (regs_q[`ACR_OFS_PWRDN] & ~`ACR_PWRDN_MASK) == 8'h00)
    else $error("power-down reserved bit set");

  // write frame reaches power-down controls
  chk_pd_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lnk.frame_valid && clk_en && cmd.op == `ACR_OP_WRITE && cmd.addr == `ACR_OFS_PWRDN
    |=> channel_a_converter_off == $past(cmd.data[`ACR_BIT_CHA]) &&
        half_reference_buffer_off == $past(cmd.data[`ACR_BIT_HALFREF]))
    else $error("power-down write lost");

  // read answer held for the next frame
  chk_read_next: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lnk.frame_valid && clk_en && cmd.op == `ACR_OP_READ && !cmd.addr[3]
    |=> lnk.tx_word[15:8] == $past(regs_q[cmd.addr[2:0]]))
    else $error("read answer wrong");

  // set-bit command merges
  chk_set_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lnk.frame_valid && clk_en && cmd.op == `ACR_OP_SET && cmd.addr == `ACR_OFS_PROTO
    |=> regs_q[`ACR_OFS_PROTO] == ($past(regs_q[`ACR_OFS_PROTO]) | $past(cmd.data)))
    else $error("set-bit result wrong");

  // command_operation_field 0 leaves configuration alone
  chk_nop_stable: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lnk.frame_valid && cmd.op == 4'h0 |=> regs_q[7:1] == $past(regs_q[7:1]))
    else $error("no-operation changed bank");

  // main scenarios
  cov_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
    lnk.frame_valid && cmd.op == `ACR_OP_READ ##[1:400] lnk.cs_fall);
  cov_abort: cover property (@(posedge ref_clk) disable iff (sys_rst)
    abort_evt ##[1:800] !averaging_abort_flag);
  cov_clash: cover property (@(posedge ref_clk) disable iff (sys_rst)
    late_window_evt && status_clr[`ACR_BIT_ZONE2]);
endmodule // acr_regs

// ### tb/acr_host_model.sv
`timescale 1ns/1ps
module acr_host_model
(
  // bench clock for alignment
  input wire logic ref_clk,
  // serial pins toward the device
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic sdi_pin,
  output logic conversion_start_pin,
  input wire logic sdo_out,
  // word shifted back during the frame
  output logic [15:0] rd_word,
  output logic rd_done
);
  // idle pins: selected off, clock parked low
  initial
  begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin = 1'b0;
    conversion_start_pin = 1'b1;
    rd_word = 16'h0000;
    rd_done = 1'b0;
  end
  // one frame, msb first, data set on falling sclk, sampled late in the bit
  task automatic xfer(input logic [15:0] w, input bit drop_start);
    @(posedge ref_clk);
    #2;
    cs_n_pin = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--)
    begin
      sdi_pin = w[i];
      conversion_start_pin = !(drop_start && i == 8);
      #100 sclk_pin = 1'b1;
      #95 rd_word[i] = sdo_out;
      #5 sclk_pin = 1'b0;
    end
    #100 cs_n_pin = 1'b1;
    // released data line shows no stale level
    sdi_pin = ~sdi_pin;
    conversion_start_pin = 1'b1;
    rd_done = ~rd_done;
    // gap before the next frame, long enough for the update to land
    #400;
  endtask
endmodule // acr_host_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import acr_pkg::*;
  // design pins
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic late_window_evt = 1'b0;
  logic averaging_busy = 1'b0;
  logic cs_n_pin, sclk_pin, sdi_pin, conversion_start_pin, sdo_out, sdo_oe;
  logic late_window_transfer_flag, averaging_abort_flag;
  logic half_reference_buffer_off, channel_b_converter_off;
  logic channel_a_converter_off, internal_reference_off;
  acr_byte_type cfg_out [8];
  // bench state
  acr_byte_type exp_reg [8];
  acr_byte_type rnd;
  logic [15:0] exp_q [$];
  logic [15:0] rd_word;
  logic [15:0] pend;
  logic rd_done;
  int err_count = 0;
  int checked = 0;
  int seed = 26;

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  acr_regs dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
    .conversion_start_pin(conversion_start_pin), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .late_window_evt(late_window_evt), .averaging_busy(averaging_busy),
    .late_window_transfer_flag(late_window_transfer_flag),
    .averaging_abort_flag(averaging_abort_flag),
    .half_reference_buffer_off(half_reference_buffer_off),
    .channel_b_converter_off(channel_b_converter_off),
    .channel_a_converter_off(channel_a_converter_off),
    .internal_reference_off(internal_reference_off),
    .read_protocol_select(cfg_out[2]), .output_lane_count(cfg_out[3]),
    .clock_retimer_setup(cfg_out[4]), .output_word_format(cfg_out[5]),
    .averaging_setup(cfg_out[6]), .half_reference_offset(cfg_out[7])
  );

  acr_host_model host (
    .ref_clk(ref_clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
    .conversion_start_pin(conversion_start_pin), .sdo_out(sdo_out),
    .rd_word(rd_word), .rd_done(rd_done)
  );

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t read word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // writable bits of each register
  function automatic acr_byte_type msk(input logic [3:0] a);
    return (a == 4'h0) ? 8'h06 : ((a == 4'h1) ? 8'h2B : 8'hFF);
  endfunction

  // all output levels: sdo_oe and sdo_out against zero, the rest against the bench's register copy
  task automatic chk_ports();
    chk_out({6'h00, sdo_oe, sdo_out}, 8'h00);
    chk_out({5'h00, late_window_transfer_flag, averaging_abort_flag, 1'h0}, exp_reg[0]);
    chk_out({2'h0, half_reference_buffer_off, 1'h0, channel_b_converter_off, 1'h0,
      channel_a_converter_off, internal_reference_off}, exp_reg[1]);
    for (int a = 2; a < 8; a++)
      chk_out(cfg_out[a], exp_reg[a]);
  endtask

  // one command frame; notes the word expected back and updates the copy
  task automatic frame(input logic [3:0] op, input logic [3:0] a, input acr_byte_type d,
    input bit drop);
    exp_q.push_back(pend);
    host.xfer({op, a, d}, drop);
    pend = 16'h0000;
    if (!drop && !a[3])
    begin
      case (op)
        4'h1: exp_reg[a[2:0]] = (a == 4'h0) ? (exp_reg[0] & ~(d & 8'h06)) : (d & msk(a));
        4'h5: if (a != 4'h0) exp_reg[a[2:0]] |= d & msk(a);
        4'h6: exp_reg[a[2:0]] &= ~(d & msk(a));
        default: ;
      endcase
      if (op == 4'h2)
        pend = {exp_reg[a[2:0]], 8'h00};
    end
    chk_ports();
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // read words come back one per frame
  initial
  begin
    // skip the idle level settling at time zero
    @(negedge sys_rst);
    forever
    begin
      @(rd_done);
      chk_word(rd_word, exp_q.pop_front());
    end
  end

  // watchdog
  initial
  begin
    #1000000;
    err_count++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    for (int a = 0; a < 8; a++)
      exp_reg[a] = 8'h00;
    pend = 16'h0000;
    repeat (6) @(posedge ref_clk);
    #2 sys_rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_ports();
    for (int a = 0; a < 9; a++)
      frame(4'h2, a[3:0], 8'h00, 0);
    tend("reset values");
    for (int a = 2; a < 8; a++)
    begin
      rnd = 8'($random(seed));
      frame(4'h1, a[3:0], (a == 2) ? (rnd & 8'hFC) : rnd, 0);
    end
    for (int a = 2; a < 8; a++)
      frame(4'h2, a[3:0], 8'h00, 0);
    tend("random config");
    frame(4'h1, 4'h1, 8'hFF, 0);
    frame(4'h6, 4'h1, 8'h08, 0);
    frame(4'h5, 4'h1, 8'h14, 0);
    frame(4'h2, 4'h1, 8'h00, 0);
    frame(4'h5, 4'h1, 8'h08, 0);
    for (int op = 0; op < 16; op++)
      if (op != 1 && op != 2 && op != 5 && op != 6)
        frame(op[3:0], 4'h3, 8'h5A, 0);
    frame(4'h2, 4'h3, 8'h00, 0);
    frame(4'h5, 4'h2, 8'h30, 0);
    frame(4'h2, 4'h2, 8'h00, 0);
    tend("power-down and opcodes");
    @(posedge ref_clk);
    #2 late_window_evt = 1'b1;
    @(posedge ref_clk);
    #2 late_window_evt = 1'b0;
    exp_reg[0] |= 8'h04;
    averaging_busy = 1'b1;
    exp_reg[0] |= 8'h02;
    frame(4'h2, 4'h0, 8'h00, 0);
    averaging_busy = 1'b0;
    frame(4'h5, 4'h0, 8'hFF, 0);
    frame(4'h1, 4'h0, 8'hF9, 0);
    frame(4'h2, 4'h0, 8'h00, 0);
    frame(4'h6, 4'h0, 8'h04, 0);
    frame(4'h1, 4'h0, 8'h02, 0);
    frame(4'h2, 4'h0, 8'h00, 0);
    tend("status flags");
    // frozen clock enable keeps every output
    @(posedge ref_clk);
    #2 clk_en = 1'b0;
    repeat (5) @(posedge ref_clk);
    chk_ports();
    #2 clk_en = 1'b1;
    repeat (4) @(posedge ref_clk);
    tend("clock enable freeze");
    frame(4'h1, 4'h4, 8'hFF, 1);
    frame(4'h2, 4'h4, 8'h00, 0);
    frame(4'h1, 4'h5, 8'hAA, 0);
    @(posedge ref_clk);
    #2 sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2 sys_rst = 1'b0;
    for (int a = 0; a < 8; a++)
      exp_reg[a] = 8'h00;
    pend = 16'h0000;
    repeat (4) @(posedge ref_clk);
    chk_ports();
    frame(4'h2, 4'h5, 8'h00, 0);
    frame(4'h0, 4'h0, 8'h00, 0);
    tend("refused frame and reset");
    give_verdict();
  end
endmodule // testbench
